// File: hw/gate_ilk_pkg.sv
// Constants shared by the inverter gate interlock device end and its controller end.
// Assumes a single 100 MHz clock common to both ends.
package gate_ilk_pkg;

  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned PHASES           = 3;
  // Shortest command pulse honoured, in microseconds
  localparam int unsigned MIN_PULSE_US     = 1;
  localparam int unsigned MIN_PULSE_CYC    = MIN_PULSE_US * CLK_MHZ;
  // Fault clear timeout, milliseconds
  localparam int unsigned FAULT_CLEAR_MS   = 6;
  localparam int unsigned FAULT_CLEAR_CYC  = FAULT_CLEAR_MS * 1000 * CLK_MHZ;
  // Overcurrent blanking, microseconds
  localparam int unsigned OC_BLANK_US      = 3;
  localparam int unsigned OC_BLANK_CYC     = OC_BLANK_US * CLK_MHZ;
  // Host dead time between the two commands of a phase, microseconds
  localparam int unsigned DEAD_TIME_US     = 2;
  localparam int unsigned DEAD_TIME_CYC    = DEAD_TIME_US * CLK_MHZ;
  localparam int unsigned CNT_W            = 20;

  typedef enum logic [1:0] {
    FLT_IDLE  = 2'b00,
    FLT_ACTIVE = 2'b01,
    FLT_WAIT  = 2'b11
  } fault_state_e;

endpackage : gate_ilk_pkg

// File: hw/gate_ilk_if.sv
// Interface joining the controller end and the inverter device end.
// The testbench resolves the open-drain enable/fault line from the enables.
`timescale 1ns/1ps
`default_nettype none
interface gate_ilk_if;
  // Active-low commands, bit 0..2 = phase U, V, W
  logic [2:0] upper_cmd_n;
  logic [2:0] lower_cmd_n;
  // Command pin drive enables; low means the pin floats and reads inactive
  logic [2:0] upper_cmd_oe;
  logic [2:0] lower_cmd_oe;
  // Open-drain enable/fault line: each party may only pull low
  logic       host_line_oe;
  logic       dev_line_oe;
  logic       enable_fault_line_n;

  modport host (
    output upper_cmd_n, lower_cmd_n, upper_cmd_oe, lower_cmd_oe, host_line_oe,
    input  enable_fault_line_n
  );
  modport dev (
    input  upper_cmd_n, lower_cmd_n, upper_cmd_oe, lower_cmd_oe,
    output dev_line_oe,
    input  enable_fault_line_n
  );
endinterface : gate_ilk_if
`default_nettype wire

// File: hw/gate_ilk_dev.sv
// Device end: input filtering, cross-conduction interlock and fault line control.
// Assumes pins are asynchronous to CLOCK_I and protection sensors are raw levels.
// The enable/fault line arrives already resolved from both open-drain pulls.
`timescale 1ns/1ps
`default_nettype none
module gate_ilk_dev
  import gate_ilk_pkg::*;
#(
  parameter int unsigned FAULT_CLEAR_CYCLES = FAULT_CLEAR_CYC
) (
  // Clock and reset
  input  wire logic       CLOCK_I,
  input  wire logic       RST_N_I,
  // Link
  gate_ilk_if.dev         link,
  // Protection sensors
  input  wire logic       OVERCURRENT_I,
  input  wire logic       LOWER_SUPPLY_UV_I,
  input  wire logic [2:0] UPPER_SUPPLY_UV_I,
  // Gate drives, active high
  output logic      [2:0] UPPER_GATE_O,
  output logic      [2:0] LOWER_GATE_O,
  output logic            FAULT_O
);

  // ==========================================================
  // Synchronisers
  // Commands, enables, sensors and the shared line all pass two flops;
  // the pull-up of a floating command is applied only after them.
  localparam logic [17:0] PIN_IDLE = 18'h1003f;

  logic [17:0] s1, s2;
  logic [17:0] pin_in;

  always_comb begin
    pin_in = {UPPER_SUPPLY_UV_I, LOWER_SUPPLY_UV_I, OVERCURRENT_I,
              link.enable_fault_line_n,
              link.upper_cmd_oe, link.lower_cmd_oe,
              link.upper_cmd_n, link.lower_cmd_n};
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s1 <= PIN_IDLE;
      s2 <= PIN_IDLE;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
    end
  end

  logic [2:0] up_n_s;
  logic [2:0] lo_n_s;
  logic [2:0] up_oe_s;
  logic [2:0] lo_oe_s;
  logic [2:0] uuv_s;
  logic       line_s;
  logic       oc_s;
  logic       luv_s;
  logic [5:0] cmd_s;

  always_comb begin
    {uuv_s, luv_s, oc_s, line_s, up_oe_s, lo_oe_s, up_n_s, lo_n_s} = s2;
    // Bit 3..5 upper U V W, bit 0..2 lower; a floating pin reads inactive
    cmd_s = {up_n_s | ~up_oe_s, lo_n_s | ~lo_oe_s};
  end

  // ==========================================================
  // Short pulse rejection: a level change counts once stable 1 us
  // Every command edge is delayed by the filter time; in return no
  // glitch shorter than that can ever reach a gate.
  wire logic [5:0] flt;

  for (genvar i = 0; i < 6; i++) begin : g_filt
    logic [7:0] pcnt;
    logic [7:0] next_pcnt;
    logic       lvl;
    logic       next_lvl;

    always_comb begin
      next_pcnt = 8'h00;
      next_lvl  = lvl;
      if (cmd_s[i] != lvl) begin
        if (pcnt == 8'(MIN_PULSE_CYC - 1)) begin
          next_lvl = cmd_s[i];
        end else begin
          next_pcnt = pcnt + 8'h01;
        end
      end
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
        lvl  <= 1'b1;
        pcnt <= 8'h00;
      end else begin
        lvl  <= next_lvl;
        pcnt <= next_pcnt;
      end
    end

    assign flt[i] = lvl;
  end

  // ==========================================================
  // Overcurrent blanking: trip only after a sustained excess
  // Any gap in the excess restarts the count, so a train of short
  // current spikes never trips however long it lasts.
  logic [8:0] ocnt, next_ocnt;
  logic       oc_trip, next_oc_trip;

  always_comb begin
    next_ocnt    = oc_s ? ocnt : 9'h000;
    next_oc_trip = 1'b0;
    if (oc_s) begin
      if (ocnt == 9'(OC_BLANK_CYC - 1)) next_oc_trip = 1'b1;
      else next_ocnt = ocnt + 9'h001;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ocnt    <= 9'h000;
      oc_trip <= 1'b0;
    end else begin
      ocnt    <= next_ocnt;
      oc_trip <= next_oc_trip;
    end
  end

  // ==========================================================
  // Fault state: held while cause stands and for at least the clear time from entry
  fault_state_e   fst, next_fst;
  logic [CNT_W-1:0] fcnt, next_fcnt;
  logic           cause;

  always_comb begin
    // Lower supply undervoltage holds the fault for as long as it lasts;
    // upper supply undervoltage never reaches the fault line
    cause     = oc_trip | luv_s;
    next_fst  = fst;
    next_fcnt = fcnt;
    case (fst)
      FLT_IDLE: begin
        if (cause) begin
          next_fst  = FLT_ACTIVE;
          next_fcnt = '0;
        end
      end
      FLT_ACTIVE, FLT_WAIT: begin
        // Timer runs from fault entry; release needs cause gone too
        if (fcnt != CNT_W'(FAULT_CLEAR_CYCLES - 1)) next_fcnt = fcnt + 1'b1;
        next_fst = cause ? FLT_ACTIVE : FLT_WAIT;
        if (!cause && fcnt == CNT_W'(FAULT_CLEAR_CYCLES - 1)) begin
          next_fst = FLT_IDLE;
        end
      end
      default: next_fst = FLT_ACTIVE;
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      fst  <= FLT_IDLE;
      fcnt <= '0;
    end else begin
      fst  <= next_fst;
      fcnt <= next_fcnt;
    end
  end

  // ==========================================================
  // Gate outputs and open-drain drive
  logic [2:0] next_up_g, next_lo_g, both_on;
  logic       next_flt_o, run;

  always_comb begin
    next_flt_o = (fst != FLT_IDLE) | cause;
    // Line sampled low by others disables; own pull-down also reads low
    run        = line_s & ~next_flt_o;
    // Overlapping commands blank the phase rather than pick a side, so a
    // host that breaks its dead time still cannot short the bridge leg
    both_on    = ~flt[5:3] & ~flt[2:0];
    for (int p = 0; p < PHASES; p++) begin
      next_up_g[p] = 1'b0;
      next_lo_g[p] = 1'b0;
      if (run && !both_on[p]) begin
        next_up_g[p] = ~flt[3+p] & ~uuv_s[p];
        next_lo_g[p] = ~flt[p] & ~uuv_s[p];
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      UPPER_GATE_O     <= 3'h0;
      LOWER_GATE_O     <= 3'h0;
      FAULT_O          <= 1'b0;
      link.dev_line_oe <= 1'b0;
    end else begin
      UPPER_GATE_O     <= next_up_g;
      LOWER_GATE_O     <= next_lo_g;
      FAULT_O          <= next_flt_o;
      link.dev_line_oe <= next_flt_o;
    end
  end

endmodule : gate_ilk_dev
`default_nettype wire

// File: hw/gate_ilk_host.sv
// Controller end: turns requested phase levels into active-low commands with
// dead time, and holds the module disabled after a fault until software acks.
// Assumes the enable/fault line arrives asynchronously.
`timescale 1ns/1ps
`default_nettype none
module gate_ilk_host
  import gate_ilk_pkg::*;
(
  // Clock and reset
  input  wire logic       CLOCK_I,
  input  wire logic       RST_N_I,
  // User side: per phase, 1 = upper on, 0 = lower on; enable gates both
  input  wire logic [2:0] PHASE_HIGH_I,
  input  wire logic [2:0] PHASE_EN_I,
  input  wire logic       RUN_I,
  input  wire logic       FAULT_ACK_I,
  output logic            FAULT_SEEN_O,
  // Link
  gate_ilk_if.host        link
);

  logic s1, s2;
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
    end else begin
      s1 <= link.enable_fault_line_n;
      s2 <= s1;
    end
  end

  // ==========================================================
  // Fault hold: set wins over acknowledge
  logic seen, next_seen, hold, next_hold;
  logic [1:0] hold_d, next_hold_d;
  always_comb begin
    // Own pull shows in s2 two cycles late, so the mask covers that tail
    next_seen   = (~s2 & ~hold & ~hold_d[0] & ~hold_d[1]) | (seen & ~FAULT_ACK_I);
    next_hold   = ~RUN_I | next_seen;
    next_hold_d = {hold_d[0], hold};
  end

  // ==========================================================
  // Dead time per phase: both commands off for DEAD_TIME_CYC on change
  logic [2:0] up_n, lo_n, next_up_n, next_lo_n;
  logic [2:0] cur, next_cur;
  logic [7:0] dcnt [3];
  logic [7:0] next_dcnt [3];

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      next_cur[p]  = cur[p];
      next_dcnt[p] = 8'h00;
      next_up_n[p] = 1'b1;
      next_lo_n[p] = 1'b1;
      if (!hold && PHASE_EN_I[p]) begin
        if (PHASE_HIGH_I[p] != cur[p] || dcnt[p] != 8'h00) begin
          // Blank both until the dead time has run out
          if (dcnt[p] == 8'(DEAD_TIME_CYC - 1)) next_cur[p] = PHASE_HIGH_I[p];
          else next_dcnt[p] = dcnt[p] + 8'h01;
        end else begin
          next_up_n[p] = ~cur[p];
          next_lo_n[p] = cur[p];
        end
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      seen <= 1'b0;
      hold <= 1'b1;
      hold_d <= 2'h3;
      cur  <= 3'h0;
      up_n <= 3'h7;
      lo_n <= 3'h7;
      for (int p = 0; p < 3; p++) dcnt[p] <= 8'h00;
      FAULT_SEEN_O      <= 1'b0;
      link.host_line_oe <= 1'b1;
    end else begin
      seen <= next_seen;
      hold <= next_hold;
      hold_d <= next_hold_d;
      cur  <= next_cur;
      up_n <= next_up_n;
      lo_n <= next_lo_n;
      for (int p = 0; p < 3; p++) dcnt[p] <= next_dcnt[p];
      FAULT_SEEN_O      <= next_seen;
      link.host_line_oe <= next_hold;
    end
  end

  assign link.upper_cmd_n  = up_n;
  assign link.lower_cmd_n  = lo_n;
  assign link.upper_cmd_oe = 3'h7;
  assign link.lower_cmd_oe = 3'h7;

endmodule : gate_ilk_host
`default_nettype wire

// File: testbench/gate_ilk_asserts.sv
// Checker on the link between the controller end and the device end.
// Sees only the interface signals; the bench instantiates it beside the link.
`timescale 1ns/1ps
`default_nettype none
module gate_ilk_asserts #(
  parameter int unsigned FAULT_CLEAR_CYCLES = 50
) (
  // Clock and reset
  input wire logic       CLOCK_I,
  input wire logic       RST_N_I,
  // Link signals
  input wire logic [2:0] upper_cmd_n,
  input wire logic [2:0] lower_cmd_n,
  input wire logic       host_line_oe,
  input wire logic       dev_line_oe,
  input wire logic       enable_fault_line_n
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  // =====================================================================
  // Fault length counter
  logic [19:0] held;
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) held <= 20'h0;
    else held <= dev_line_oe ? held + 20'h1 : 20'h0;
  end
  // =====================================================================
  // Properties
  AST_NO_OVERLAP: assert property ((~upper_cmd_n & ~lower_cmd_n) == 3'h0)
    else $error("both commands of a phase active");
  for (genvar p = 0; p < 3; p++) begin : g_dead
    AST_DEAD_UPPER: assert property ($fell(upper_cmd_n[p]) |-> $past(lower_cmd_n[p], 100))
      else $error("upper command without dead time");
    AST_DEAD_LOWER: assert property ($fell(lower_cmd_n[p]) |-> $past(upper_cmd_n[p], 100))
      else $error("lower command without dead time");
  end
  AST_FAULT_PULLS: assert property (dev_line_oe |-> !enable_fault_line_n)
    else $error("fault line not low during fault");
  AST_HOST_REACTS: assert property ($fell(enable_fault_line_n) && !host_line_oe |-> ##[1:5] host_line_oe)
    else $error("controller did not hold the line");
  AST_RESTART_HELD: assert property ($fell(dev_line_oe) |-> host_line_oe)
    else $error("fault released while controller not holding");
  AST_FAULT_MIN_ROSE: assert property ($rose(dev_line_oe) |-> dev_line_oe [*8])
    else $error("fault pulse too short");
  AST_FAULT_MIN_TIME: assert property ($fell(dev_line_oe) |-> $past(held) >= 20'(FAULT_CLEAR_CYCLES))
    else $error("fault released before clear timeout");
endmodule : gate_ilk_asserts
`default_nettype wire

// File: testbench/gate_ilk_tb.sv
// Bench: controller and device ends on one link, plus a second device end
// whose commands and line the bench drives itself, breaking host rules.
`timescale 1ns/1ps
`default_nettype none
module gate_ilk_tb;
  localparam int unsigned FCLR = 50;
  logic       clk, rst_n, run, ack, oc, luv, seen, flt_a, flt_b;
  logic [2:0] uuv, ph_high, ph_en, up_a, lo_a, up_b, lo_b;
  int         mismatches, comparisons;
  gate_ilk_if la();
  gate_ilk_if lb();
  assign la.enable_fault_line_n = ~(la.host_line_oe | la.dev_line_oe);
  assign lb.enable_fault_line_n = ~(lb.host_line_oe | lb.dev_line_oe);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  gate_ilk_host i_gate_ilk_host (.CLOCK_I(clk), .RST_N_I(rst_n), .PHASE_HIGH_I(ph_high),
    .PHASE_EN_I(ph_en), .RUN_I(run), .FAULT_ACK_I(ack), .FAULT_SEEN_O(seen), .link(la.host));
  gate_ilk_dev #(.FAULT_CLEAR_CYCLES(FCLR)) i_gate_ilk_dev (.CLOCK_I(clk), .RST_N_I(rst_n),
    .link(la.dev), .OVERCURRENT_I(oc), .LOWER_SUPPLY_UV_I(1'b0), .UPPER_SUPPLY_UV_I(3'h0),
    .UPPER_GATE_O(up_a), .LOWER_GATE_O(lo_a), .FAULT_O(flt_a));
  gate_ilk_dev #(.FAULT_CLEAR_CYCLES(FCLR)) i_gate_ilk_dev_b (.CLOCK_I(clk), .RST_N_I(rst_n),
    .link(lb.dev), .OVERCURRENT_I(1'b0), .LOWER_SUPPLY_UV_I(luv), .UPPER_SUPPLY_UV_I(uuv),
    .UPPER_GATE_O(up_b), .LOWER_GATE_O(lo_b), .FAULT_O(flt_b));
  gate_ilk_asserts #(.FAULT_CLEAR_CYCLES(FCLR)) i_gate_ilk_asserts (.CLOCK_I(clk),
    .RST_N_I(rst_n), .upper_cmd_n(la.upper_cmd_n), .lower_cmd_n(la.lower_cmd_n),
    .host_line_oe(la.host_line_oe), .dev_line_oe(la.dev_line_oe),
    .enable_fault_line_n(la.enable_fault_line_n));
  // =====================================================================
  // Tasks
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic cmp3(input logic [2:0] got, input logic [2:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp3
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic drive_b(input logic [2:0] un, ln, uo, lo);
    lb.upper_cmd_n = un;
    lb.lower_cmd_n = ln;
    lb.upper_cmd_oe = uo;
    lb.lower_cmd_oe = lo;
  endtask : drive_b
  task automatic wait_clear(input logic side_b, output int n);
    for (n = 0; n < 4000 && (side_b ? flt_b : flt_a) === 1'b1; n++) cyc(1);
    if (n == 4000) begin
      mismatches++;
      final_report();
    end
  endtask : wait_clear
  task automatic check_a(input logic on);
    cmp3(up_a, on ? ph_high & ph_en : 3'h0);
    cmp3(lo_a, on ? ~ph_high & ph_en : 3'h0);
  endtask : check_a
  // Flip the lower commands for 60 cycles; the gates must not follow
  task automatic glitch(input logic [2:0] lvl);
    logic [2:0] acc;
    acc = 3'h0;
    drive_b(3'h7, lvl, 3'h7, 3'h7);
    cyc(150);
    lb.lower_cmd_n = ~lvl;
    for (int i = 0; i < 200; i++) begin
      if (i == 60) lb.lower_cmd_n = lvl;
      cyc(1);
      acc = acc | (lo_b ^ ~lvl);
    end
    cmp3(acc, 3'h0);
  endtask : glitch
  function automatic logic [5:0] exp_gates(input logic [2:0] un, ln, uo, lo, uv);
    logic [2:0] u;
    logic [2:0] l;
    u = ~un & uo;
    l = ~ln & lo;
    return {u & ~l & ~uv, l & ~u & ~uv};
  endfunction : exp_gates
  // =====================================================================
  // Main sequence
  initial begin
    logic [5:0] g;
    logic [2:0] un, ln, uo;
    int n;
    void'($urandom(97));
    rst_n = 1'b0;
    {run, ack, oc, luv, uuv, ph_high, ph_en} = 13'h0;
    drive_b(3'h7, 3'h7, 3'h7, 3'h7);
    lb.host_line_oe = 1'b0;
    mismatches = 0;
    comparisons = 0;
    cyc(2);
    rst_n = 1'b1;
    // Corners first: overlap on every phase whose upper pin is driven, a floating upper pin, upper UV on V
    for (int i = 0; i < 10; i++) begin
      un  = (i < 2) ? 3'h0 : 3'($urandom);
      ln  = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'($urandom);
      uo  = (i == 1) ? 3'h5 : 3'($urandom | $urandom);
      uuv = (i == 2) ? 3'h2 : 3'($urandom & $urandom & $urandom);
      g   = exp_gates(un, ln, uo, 3'h7, uuv);
      drive_b(un, ln, uo, 3'h7);
      cyc(120);
      cmp3(up_b, g[5:3]);
      cmp3(lo_b, g[2:0]);
      cmp3({2'h0, flt_b}, 3'h0);
      drive_b(3'h7, 3'h7, 3'h7, 3'h7);
      uuv = 3'h0;
      cyc(220);
      cmp3(up_b | lo_b, 3'h0);
    end
    glitch(3'h6);
    lb.host_line_oe = 1'b1;
    cyc(8);
    cmp3(lo_b, 3'h0);
    lb.host_line_oe = 1'b0;
    luv = 1'b1;
    cyc(8);
    cmp3({2'h0, flt_b}, 3'h1);
    luv = 1'b0;
    wait_clear(1'b1, n);
    cmp3({2'h0, n + 8 >= FCLR}, 3'h1);
    run = 1'b1;
    ack = 1'b1;
    cyc(1);
    ack = 1'b0;
    for (int i = 0; i < 6; i++) begin
      ph_high = 3'($urandom);
      ph_en = (i == 0) ? 3'h7 : 3'($urandom);
      cyc(420);
      check_a(1'b1);
    end
    run = 1'b0;
    cyc(20);
    check_a(1'b0);
    run = 1'b1;
    ph_en = 3'h7;
    cyc(420);
    oc = 1'b1;
    cyc(200);
    oc = 1'b0;
    cmp3({2'h0, flt_a}, 3'h0);
    cyc(10);
    oc = 1'b1;
    cyc(320);
    cmp3({seen, flt_a, |(up_a | lo_a)}, 3'h6);
    oc = 1'b0;
    wait_clear(1'b0, n);
    cyc(420);
    check_a(1'b0);
    ack = 1'b1;
    cyc(1);
    ack = 1'b0;
    cyc(420);
    check_a(1'b1);
    final_report();
  end
endmodule : gate_ilk_tb
`default_nettype wire
